//--- tpi_map.vh
// Purpose: offsets, field positions and reset values of the timer prescaler
// Assumes: 8-bit register port with 16-bit addresses
// Notes:   included by tpi_timer.v only
`ifndef TPI_MAP_VH
`define TPI_MAP_VH

// register addresses
`define TPI_ADDR_PORT5_DIR  16'hff25
`define TPI_ADDR_PRESCALE   16'hff61
`define TPI_ADDR_OUT_CTRL1  16'hff6b

// reset values
`define TPI_RST_PORT5_DIR   8'hff
`define TPI_RST_PRESCALE    8'h00
`define TPI_RST_OUT_CTRL1   8'h00

// prescaler register fields
`define TPI_SECOND_EDGE_HI  7
`define TPI_SECOND_EDGE_LO  6
`define TPI_PRIMARY_EDGE_HI 5
`define TPI_PRIMARY_EDGE_LO 4
`define TPI_CLK_SEL_HI      1
`define TPI_CLK_SEL_LO      0
`define TPI_PRESCALE_MASK   8'hf3

// edge encodings
`define TPI_EDGE_FALL       2'h0
`define TPI_EDGE_RISE       2'h1
`define TPI_EDGE_BOTH       2'h3

// count clock encodings
`define TPI_CLK_FX          2'h0
`define TPI_CLK_FX4         2'h1
`define TPI_CLK_FX32        2'h2
`define TPI_CLK_EDGE        2'h3

// output control register fields
`define TPI_OC_ENABLE       0
`define TPI_OC_RESET_CMD    2
`define TPI_OC_SET_CMD      3
`define TPI_OC_KEEP_MASK    8'h13

// port 5 pins that carry the timer outputs
`define TPI_DIR_PIN4        4
`define TPI_DIR_PIN6        6

// prescaler divider: fx/4, fx/16 sampling, fx/32
`define TPI_DIV_W           5
`define TPI_DIV4_MASK       5'h03
`define TPI_DIV16_MASK      5'h0f
`define TPI_DIV32_MASK      5'h1f

`endif

//--- tpi_timer.v
// Purpose: two 16-bit timers with prescaler, input edge select, interval
//          and pulse-generator modes, port 5 direction register
// Assumes: registers written over a 16-bit address, 8-bit data port; mode and
//          compare values come from the rest of the timer as plain inputs
// Notes:   one clock clk_sys (system_osc_clock), asynchronous reset rst
//
// Behaviour
// - bits 7:6 pick second input edge
// - bits 5:4 pick primary input edge
// - bits 1:0 pick fx, fx/4, fx/32, edge
// - high pin after reset gives immediate rise
// - re-enable after stop gives no false rise
// - reset clears both prescaler registers
// - set/reset command bits read back zero
// - direction bit 0 output, 1 input
// - reset sets all direction bits to one
// - interval match clears counter, raises request
// - interval mode is clear-on-first-compare
// - pulse mode: cycle first, width second compare
`timescale 1ns/100ps
`default_nettype none
`include "tpi_map.vh"

module tpi_timer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  input  wire        bank_sel,
  output reg  [7:0]  reg_rdata,
  input  wire [1:0]  primary_input_pin,
  input  wire [1:0]  second_input_pin,
  input  wire [1:0]  run_enable,
  input  wire [1:0]  interval_mode,
  input  wire [1:0]  pulse_mode,
  input  wire [31:0] first_compare_value,
  input  wire [31:0] second_compare_value,
  input  wire        output_enable_0,
  output reg  [7:0]  port5_direction,
  output wire [1:0]  timer_output_pin,
  output wire [1:0]  timer_output_oe,
  output reg  [1:0]  compare_match_irq,
  output reg  [1:0]  second_edge_evt,
  output reg  [31:0] timer_count
);

  // edge decode shared by all inputs; the prohibited code matches nothing
  function edge_hit;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
      case (sel)
        `TPI_EDGE_FALL: edge_hit = prev & ~cur;
        `TPI_EDGE_RISE: edge_hit = ~prev & cur;
        `TPI_EDGE_BOTH: edge_hit = prev ^ cur;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg [7:0]  prescale_edge_select_0;       // channel 0 prescaler
  reg [7:0]  prescale_edge_select_1;       // channel 1 prescaler
  reg [7:0]  output_control_1;             // kept bits only
  reg        output_ff_set_cmd;            // one-cycle command pulse
  reg        output_ff_reset_cmd;          // one-cycle command pulse
  reg [`TPI_DIV_W-1:0] div_cnt;            // free-running prescaler
  reg [1:0]  sync_p1;                      // primary pin first stage
  reg [1:0]  sync_p2;                      // primary pin second stage
  reg [1:0]  sync_s1;                      // second pin first stage
  reg [1:0]  sync_s2;                      // second pin second stage
  reg [1:0]  armed;                        // counter enabled at least once
  reg [1:0]  prev_p;                       // fx/16 sample of primary pin
  reg [1:0]  prev_s;                       // last level of second pin
  reg [1:0]  out_ff;                       // timer output flip-flops

  // a strobe fires when the masked low divider bits are all ones
  wire strobe4  = ((div_cnt & `TPI_DIV4_MASK) == `TPI_DIV4_MASK);
  wire strobe16 = ((div_cnt & `TPI_DIV16_MASK) == `TPI_DIV16_MASK);
  wire strobe32 = (div_cnt == `TPI_DIV32_MASK);
  wire [1:0] out_enable;

  assign out_enable = {output_control_1[`TPI_OC_ENABLE], output_enable_0};
  assign timer_output_pin = out_ff & out_enable;
  // buffer on while the direction bit is 0
  assign timer_output_oe = {~port5_direction[`TPI_DIR_PIN6],
                            ~port5_direction[`TPI_DIR_PIN4]};

  // register writes; prescale registers share one address, bank_sel picks
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port5_direction        <= `TPI_RST_PORT5_DIR;
      prescale_edge_select_0 <= `TPI_RST_PRESCALE;
      prescale_edge_select_1 <= `TPI_RST_PRESCALE;
      output_control_1       <= `TPI_RST_OUT_CTRL1;
      output_ff_set_cmd      <= 1'b0;
      output_ff_reset_cmd    <= 1'b0;
    end else begin
      output_ff_set_cmd   <= 1'b0;
      output_ff_reset_cmd <= 1'b0;
      if (reg_wr && reg_addr == `TPI_ADDR_PORT5_DIR) begin
        port5_direction <= reg_wdata;
      end else if (reg_wr && reg_addr == `TPI_ADDR_PRESCALE) begin
        // bits 3:2 are fixed at zero
        if (bank_sel) begin
          prescale_edge_select_1 <= reg_wdata & `TPI_PRESCALE_MASK;
        end else begin
          prescale_edge_select_0 <= reg_wdata & `TPI_PRESCALE_MASK;
        end
      end else if (reg_wr && reg_addr == `TPI_ADDR_OUT_CTRL1) begin
        // command bits are not stored so they read back zero
        output_control_1    <= reg_wdata & `TPI_OC_KEEP_MASK;
        output_ff_set_cmd   <= reg_wdata[`TPI_OC_SET_CMD];
        output_ff_reset_cmd <= reg_wdata[`TPI_OC_RESET_CMD];
      end
    end
  end

  // registered read port; unmapped addresses read zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `TPI_ADDR_PORT5_DIR) begin
        reg_rdata <= port5_direction;
      end else if (reg_addr == `TPI_ADDR_PRESCALE) begin
        reg_rdata <= bank_sel ? prescale_edge_select_1
                              : prescale_edge_select_0;
      end else if (reg_addr == `TPI_ADDR_OUT_CTRL1) begin
        reg_rdata <= output_control_1;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // free-running divider gives fx/4, fx/16 sampling and fx/32 strobes
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt <= {`TPI_DIV_W{1'b0}};
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // pins cross in through two flip-flops before any edge logic
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_p1 <= 2'h0;
      sync_p2 <= 2'h0;
      sync_s1 <= 2'h0;
      sync_s2 <= 2'h0;
    end else begin
      sync_p1 <= primary_input_pin;
      sync_p2 <= sync_p1;
      sync_s1 <= second_input_pin;
      sync_s2 <= sync_s1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [7:0]  psel = (ch == 0) ? prescale_edge_select_0
                                   : prescale_edge_select_1;
      wire [15:0] cmp0 = first_compare_value[16*ch +: 16];
      wire [15:0] cmp1 = second_compare_value[16*ch +: 16];
      wire [15:0] cnt  = timer_count[16*ch +: 16];
      wire        run  = run_enable[ch];
      // the pin is looked at on fx/16 strobes only, so a pulse must
      // span two of them to be seen reliably
      wire p_edge = strobe16 & edge_hit(
                      psel[`TPI_PRIMARY_EDGE_HI:`TPI_PRIMARY_EDGE_LO],
                      prev_p[ch], sync_p2[ch]);
      wire s_edge = edge_hit(
                      psel[`TPI_SECOND_EDGE_HI:`TPI_SECOND_EDGE_LO],
                      prev_s[ch], sync_s2[ch]);
      reg  tick;                           // one count clock event
      wire match0 = (cnt == cmp0);
      wire match1 = (cnt == cmp1);
      wire [1:0] cmd = (ch == 1) ? {output_ff_set_cmd, output_ff_reset_cmd}
                                 : 2'h0;

      // count clock selection
      always @* begin
        case (psel[`TPI_CLK_SEL_HI:`TPI_CLK_SEL_LO])
          `TPI_CLK_FX:   tick = 1'b1;
          `TPI_CLK_FX4:  tick = strobe4;
          `TPI_CLK_FX32: tick = strobe32;
          default:       tick = p_edge;
        endcase
      end

      // edge history is held at zero until the first enable, so a high
      // pin after reset is seen as a rise; afterwards it keeps tracking
      // even while stopped, so a re-enable finds no stale rise
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          armed[ch]  <= 1'b0;
          prev_p[ch] <= 1'b0;
          prev_s[ch] <= 1'b0;
        end else begin
          if (run) begin
            armed[ch] <= 1'b1;
          end
          if ((run || armed[ch]) && strobe16) begin
            prev_p[ch] <= sync_p2[ch];
          end
          if (run || armed[ch]) begin
            prev_s[ch] <= sync_s2[ch];
          end
        end
      end

      // counter, compare and output flip-flop
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          timer_count[16*ch +: 16] <= 16'h0000;
          compare_match_irq[ch]    <= 1'b0;
          second_edge_evt[ch]      <= 1'b0;
          out_ff[ch]               <= 1'b0;
        end else begin
          compare_match_irq[ch] <= 1'b0;
          second_edge_evt[ch]   <= run & s_edge;
          if (!run) begin
            // stopped counter holds at zero
            timer_count[16*ch +: 16] <= 16'h0000;
          end else if (tick) begin
            if ((interval_mode[ch] || pulse_mode[ch]) && match0) begin
              // period is cmp0 + 1 counts
              timer_count[16*ch +: 16] <= 16'h0000;
              compare_match_irq[ch]    <= 1'b1;
            end else begin
              timer_count[16*ch +: 16] <= cnt + 16'h0001;
              compare_match_irq[ch]    <= match0;
            end
          end
          // commands win over compare events in their cycle
          if (cmd[1]) begin
            out_ff[ch] <= 1'b1;
          end else if (cmd[0]) begin
            out_ff[ch] <= 1'b0;
          end else if (run && tick && pulse_mode[ch]) begin
            // high from cycle start until the second compare
            if (match0) begin
              out_ff[ch] <= 1'b1;
            end else if (match1) begin
              out_ff[ch] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

endmodule // tpi_timer

`default_nettype wire

//--- tpi_pulse_src.sv
// Purpose: external pulse source on the timer input pins
// Assumes: both inputs of both channels share one waveform
// Notes:   levels change on falling fx edges; width is chosen per call
`timescale 1ns/100ps
`default_nettype none
module tpi_pulse_src (
  input  wire logic       clk_sys,
  output var  logic [1:0] prim_pin,
  output var  logic [1:0] sec_pin
);
  // pins sit low until the bench says otherwise
  initial begin
    prim_pin = 2'b00;
    sec_pin  = 2'b00;
  end

  // static level, e.g. a pulled-up pin at power-up
  task automatic level(input logic v);
    prim_pin = {2{v}};
    sec_pin  = {2{v}};
  endtask

  // n pulses, each level held w fx clocks; w above 32 keeps two fx/16 samples
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      repeat (w) @(negedge clk_sys);
      level(1'b1);
      repeat (w) @(negedge clk_sys);
      level(1'b0);
    end
  endtask
endmodule // tpi_pulse_src
`default_nettype wire

//--- tpi_timer_assertions.sv
// Purpose: port-level checks of the timer prescaler block
// Assumes: bound to every tpi_timer instance
// Notes:   channel 0 is watched; channel 1 shares the same logic
`timescale 1ns/100ps
`default_nettype none
module tpi_timer_assertions (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  run_enable,
  input wire logic [1:0]  interval_mode,
  input wire logic [31:0] first_compare_value,
  input wire logic [7:0]  port5_direction,
  input wire logic [1:0]  timer_output_oe,
  input wire logic [1:0]  compare_match_irq,
  input wire logic [31:0] timer_count
);
  // one clock domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DIR_RST: assert property ($fell(rst) |-> port5_direction == 8'hff)
    else $error("direction register not all ones after reset");
  AST_OE_MAP: assert property (
    timer_output_oe == ~{port5_direction[6], port5_direction[4]})
    else $error("output enable does not follow direction bits");
  AST_IRQ_CAUSE: assert property (compare_match_irq[0] |->
    $past(timer_count[15:0]) == $past(first_compare_value[15:0]))
    else $error("match request without a compare match");
  AST_IRQ_CLEAR: assert property (compare_match_irq[0] &&
    $past(interval_mode[0]) && $past(run_enable[0])
    |-> timer_count[15:0] == 16'h0)
    else $error("counter not cleared on interval match");
  AST_IRQ_ONE: assert property (compare_match_irq[0] &&
    first_compare_value[15:0] != 16'h0 |=> !compare_match_irq[0])
    else $error("match request longer than one cycle");
  AST_CNT_STEP: assert property ($past(run_enable[0]) &&
    timer_count[15:0] != $past(timer_count[15:0])
    |-> timer_count[15:0] == $past(timer_count[15:0]) + 16'h1
      || timer_count[15:0] == 16'h0)
    else $error("counter moved by other than one");
  AST_RUN_OFF: assert property (!run_enable[0] |=>
    timer_count[15:0] == 16'h0)
    else $error("stopped counter not held at zero");
  AST_PRE_READ: assert property ($past(reg_rd) &&
    $past(reg_addr) == 16'hff61 |-> reg_rdata[3:2] == 2'b00)
    else $error("prescaler fixed bits read nonzero");
  AST_OC_READ: assert property ($past(reg_rd) &&
    $past(reg_addr) == 16'hff6b
    |-> reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0)
    else $error("output control command bits read nonzero");
endmodule // tpi_timer_assertions
bind tpi_timer tpi_timer_assertions u_chk (.clk_sys, .rst, .reg_addr,
  .reg_rd, .reg_rdata, .run_enable, .interval_mode, .first_compare_value,
  .port5_direction, .timer_output_oe, .compare_match_irq, .timer_count);
`default_nettype wire

//--- test_timer_prescaler_interval.sv
// Purpose: self-checking bench for the timer prescaler block
// Assumes: 40 MHz clk_sys, both channels driven alike
// Notes:   expectations are worked out here from field values
`timescale 1ns/100ps
`default_nettype none
module test_timer_prescaler_interval;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        bank_sel = 1'b0, output_enable_0 = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h0, reg_rdata, port5_direction;
  logic [1:0]  primary_input_pin, second_input_pin, timer_output_pin, c;
  logic [1:0]  run_enable = 2'b0, interval_mode = 2'b0, pulse_mode = 2'b0;
  logic [1:0]  timer_output_oe, compare_match_irq, second_edge_evt;
  logic [31:0] first_compare_value = 32'hffffffff, r;
  logic [31:0] second_compare_value = 32'h0, timer_count, seed = 32'h4b7d;
  int          err_count = 0, cmp_count = 0, evt = 0, n, h0, h1, k;

  always #12.5 clk_sys = ~clk_sys;
  // second-input events of both channels, counted by the bench
  always @(posedge clk_sys)
    evt <= evt + second_edge_evt[0] + second_edge_evt[1];

  tpi_timer dut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .bank_sel, .reg_rdata, .primary_input_pin, .second_input_pin,
    .run_enable, .interval_mode, .pulse_mode, .first_compare_value,
    .second_compare_value, .output_enable_0, .port5_direction,
    .timer_output_pin, .timer_output_oe, .compare_match_irq,
    .second_edge_evt, .timer_count);
  tpi_pulse_src src (.clk_sys, .prim_pin(primary_input_pin),
    .sec_pin(second_input_pin));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic fail(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("reg %h want %h", g, e));
  endtask
  task automatic chk_cnt(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("count %h want %h", g, e));
  endtask
  task automatic chk_num(input int g, input int e);
    cmp_count++;
    if (g != e) fail($sformatf("cycles %0d want %0d", g, e));
  endtask
  task automatic cnt2(input logic [15:0] e);
    chk_cnt(timer_count[15:0], e);
    chk_cnt(timer_count[31:16], e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    @(negedge clk_sys);
    {reg_addr, reg_wdata, bank_sel, reg_wr} = {a, d, b, 1'b1};
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic b, input logic [7:0] e);
    @(negedge clk_sys);
    {reg_addr, bank_sel, reg_rd} = {a, b, 1'b1};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk_reg(reg_rdata, e);
  endtask
  // both prescalers alike; only called with the counters stopped
  task automatic pre(input logic [7:0] d);
    wr(16'hff61, d, 1'b0);
    wr(16'hff61, d, 1'b1);
  endtask
  // cycles between two match requests of channel 0, bounded
  task automatic per(output int p);
    int i;
    p = 0;
    for (i = 0; i < 3000 && compare_match_irq[0] !== 1'b1; i++)
      @(negedge clk_sys);
    do begin
      @(negedge clk_sys);
      p++;
    end while (compare_match_irq[0] !== 1'b1 && p < 3000);
  endtask
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #1 src.level(1'b1);
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(16'hff25, 1'b0, 8'hff);
    rd(16'hff61, 1'b0, 8'h00);
    rd(16'hff61, 1'b1, 8'h00);
    rd(16'hff6b, 1'b0, 8'h00);
    // pin high since reset, rising edge as count clock
    pre(8'h13);
    run_enable = 2'b11;
    repeat (40) @(negedge clk_sys);
    cnt2(16'h1);
    run_enable = 2'b00;
    repeat (4) @(negedge clk_sys);
    run_enable = 2'b11;
    repeat (40) @(negedge clk_sys);
    cnt2(16'h0);
    run_enable = 2'b00;
    src.level(1'b0);
    // let the fx/16 edge history settle on the low level first
    repeat (40) @(negedge clk_sys);
    // every edge code on both inputs, slow and prompt pulses
    for (k = 0; k < 3; k++) begin
      c = (k == 2) ? 2'd3 : k[1:0];
      pre({c, c, 4'h3});
      h1 = evt;
      run_enable = 2'b11;
      src.pulse(3, 34 + 10 * k);
      repeat (40) @(negedge clk_sys);
      cnt2((k == 2) ? 16'd6 : 16'd3);
      chk_num(evt - h1, (k == 2) ? 12 : 6);
      run_enable = 2'b00;
    end
    for (k = 0; k < 4; k++) begin
      r = rnd();
      wr(16'hff25, r[7:0], 1'b0);
      rd(16'hff25, 1'b0, r[7:0]);
      chk_reg(port5_direction, r[7:0]);
      chk_reg({6'h0, timer_output_oe}, {6'h0, ~r[6], ~r[4]});
      wr(16'hff61, r[7:0], k[0]);
      rd(16'hff61, k[0], r[7:0] & 8'hf3);
      wr(16'hff6b, r[7:0] & 8'h1f, 1'b0);
      rd(16'hff6b, 1'b0, r[7:0] & 8'h13);
      rd(16'hff60, 1'b0, 8'h00);
    end
    interval_mode = 2'b11;
    for (k = 0; k < 3; k++) begin
      r = rnd();
      n = r[3:0] + 1;
      first_compare_value = {2{n[15:0]}};
      pre({6'h0, k[1:0]});
      run_enable = 2'b11;
      per(h0);
      chk_num(h0, (n + 1) * (k == 0 ? 1 : k == 1 ? 4 : 32));
      run_enable = 2'b00;
    end
    interval_mode = 2'b00;
    pulse_mode = 2'b11;
    output_enable_0 = 1'b1;
    wr(16'hff6b, 8'h01, 1'b0);
    wr(16'hff25, 8'haf, 1'b0);
    chk_reg({6'h0, timer_output_oe}, 8'h03);
    pre(8'h00);
    r = rnd();
    n = r[3:0] + 4;
    first_compare_value = {2{n[15:0]}};
    second_compare_value = {2{n[16:1]}};
    run_enable = 2'b11;
    repeat (3 * n) @(negedge clk_sys);
    h0 = 0;
    h1 = 0;
    repeat (n + 1) begin
      @(negedge clk_sys);
      h0 += timer_output_pin[0];
      h1 += timer_output_pin[1];
    end
    chk_num(h0, n / 2 + 1);
    chk_num(h1, n / 2 + 1);
    close_out();
  end

  // hang guard, well beyond the few thousand cycles the run needs
  initial begin
    #2_000_000;
    fail("watchdog expired");
    close_out();
  end
endmodule // test_timer_prescaler_interval
`default_nettype wire
